/* include/ccss_pkg.sv */
`default_nettype none
package ccss_pkg;
    localparam int unsigned DATA_W         = 8;
    localparam logic [3:0]  OFF_CTRL0      = 4'h0;
    localparam logic [3:0]  OFF_CTRL1      = 4'h4;
    localparam logic [3:0]  OFF_TXBUF      = 4'h8;
    localparam logic [3:0]  OFF_RXBUF      = 4'hc;
    localparam logic [4:0]  OFF_IRQ_STAT   = 5'h10;
    localparam logic [4:0]  OFF_IRQ_MASK   = 5'h14;
    localparam int unsigned C0_CLK_EXT     = 0;
    localparam int unsigned C0_POL         = 1;
    localparam int unsigned C0_RTS_SEL     = 2;
    localparam int unsigned C0_CTS_SEL     = 3;
    localparam int unsigned C0_DIV_LSB     = 8;
    localparam int unsigned C0_DIV_W       = 8;
    localparam int unsigned C1_TE          = 0;
    localparam int unsigned C1_TI          = 1;
    localparam int unsigned C1_RE          = 2;
    localparam int unsigned C1_RXFULL      = 3;
    localparam int unsigned C1_IRS         = 4;
    localparam int unsigned C1_ERE         = 5;
    localparam int unsigned C1_SCM         = 6;
    localparam int unsigned RB_OVR         = 12;
    localparam int unsigned IRQ_TX         = 0;
    localparam int unsigned IRQ_RX         = 1;
    localparam int unsigned IRQ_OVR        = 2;
    localparam int unsigned IRQ_W          = 3;
    localparam logic [7:0]  DIV_RESET      = 8'h04;
    localparam logic [3:0]  BIT_COUNT      = 4'h8;
endpackage : ccss_pkg
`default_nettype wire

/* rtl/ccss_top.sv */
// Notes on behaviour
// R1: External clock with RTS chosen drives RTS low once receiver is ready.
// R2: External clock with RTS chosen drives RTS high when reception begins.
// R3: Internal clock makes RTS function inert; RTS stays low.
// R4: Polarity 0: send on fall, sample on rise; 1 swaps the edges.
// R5: Send starts when enabled, buffer holds data and CTS low if chosen.
// R6: Outside master holds clock idle while start conditions are met.
// R7: Transmitter makes the shift clock; receiving sends dummy data out.
// R8: Internal clock runs once enabled and a word is in the buffer.
// R9: External clock shifts only while the peer supplies clock pulses.
// R10: Word completed while receive buffer full sets overrun flag.
// R11: Overrun leaves the receive interrupt request unchanged.
// R12: Software writes dummy transmit data per word to keep receiving.
// R13: Receive starts with receive enable, transmit enable and data present.
// R14: Smart-card mode with completion source and error output raises tx irq.
// R15: One transfer moves eight bits; rx word loads after the eighth bit.
// R16: Idle internal shift clock rests at the polarity idle level.
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ccss_top #(
    parameter int unsigned DIV_W = ccss_pkg::C0_DIV_W
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        clock_pin_i,
    output logic             clock_pin_o,
    output logic             clock_pin_oe,
    output logic             transmit_data_pin,
    input  wire logic        receive_data_pin,
    input  wire logic        cts_n_pin,
    output logic             rts_n_pin,
    output logic             irq
);
    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    // The divider register is one byte wide in the control word.
    if (DIV_W != ccss_pkg::C0_DIV_W) begin : g_bad_div_w
        $error("divider width must match the control field");
    end
    // ****************************************************************
    // Register file.
    // ****************************************************************
    logic [3:0]          ctrl0_q;
    logic [7:0]          div_q;
    logic                te_q, re_q, irs_q, ere_q, scm_q;
    logic                tbe_q;
    logic [7:0]          txbuf_q;
    logic [7:0]          rxbuf_q;
    logic                rxfull_q;
    logic                ovr_q;
    logic [2:0]          stat_q, mask_q;
    logic                rd_ack_q;
    logic [31:0]         rdata_q;
    logic                ext_clk, pol, rts_sel, cts_sel;
    assign ext_clk = ctrl0_q[ccss_pkg::C0_CLK_EXT];
    assign pol     = ctrl0_q[ccss_pkg::C0_POL];
    assign rts_sel = ctrl0_q[ccss_pkg::C0_RTS_SEL];
    assign cts_sel = ctrl0_q[ccss_pkg::C0_CTS_SEL];
    wire         wr_c0  = avs_write && avs_address == 5'(ccss_pkg::OFF_CTRL0);
    wire         wr_c1  = avs_write && avs_address == 5'(ccss_pkg::OFF_CTRL1);
    wire         wr_tb  = avs_write && avs_address == 5'(ccss_pkg::OFF_TXBUF)
                          && avs_byteenable[0];
    wire         rd_rb  = avs_read && avs_address == 5'(ccss_pkg::OFF_RXBUF)
                          && !rd_ack_q;
    wire         wr_st  = avs_write && avs_address == ccss_pkg::OFF_IRQ_STAT;
    wire         wr_mk  = avs_write && avs_address == ccss_pkg::OFF_IRQ_MASK;
    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    logic [2:0] s1_q, s2_q;
    logic [2:0] pins_raw;
    logic       sck_prev_q;
    assign pins_raw = {cts_n_pin, receive_data_pin, clock_pin_i};
    // Each pin passes two flip-flops before any logic reads it.
    for (genvar gi = 0; gi < 3; gi++) begin : g_sync
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                s1_q[gi] <= 1'b1;
                s2_q[gi] <= 1'b1;
            end else if (clk_en) begin
                s1_q[gi] <= pins_raw[gi];
                s2_q[gi] <= s1_q[gi];
            end
        end
    end
    wire sck_ext = s2_q[0];
    wire rxd_s   = s2_q[1];
    wire cts_s   = s2_q[2];
    // ****************************************************************
    // Shift engine.
    // ****************************************************************
    typedef enum logic [1:0] {
        CCSS_IDLE  = 2'b01,
        CCSS_SHIFT = 2'b10
    } ccss_state_t;
    ccss_state_t st_q;
    logic [7:0]  tsr_q, rsr_q, divc_q;
    logic [3:0]  bits_q;
    logic        isck_q;
    logic        rx_act_q;
    // Start needs enable, data present and CTS low when chosen. [R5] [R13]
    wire start_ok = te_q && !tbe_q && (!cts_sel || !cts_s);
    wire div_hit  = divc_q == 8'h00;
    wire idle_lvl = !pol;                                           // [R16]
    wire sck_now  = ext_clk ? sck_ext : isck_q;
    wire rise     = sck_now && !sck_prev_q;
    wire fall     = !sck_now && sck_prev_q;
    // Sample edge rises with polarity 0, falls with polarity 1. [R4]
    wire samp_e   = (st_q == CCSS_SHIFT) && (pol ? fall : rise);
    wire shft_e   = (st_q == CCSS_SHIFT) && (pol ? rise : fall);
    wire last_b   = samp_e && bits_q == ccss_pkg::BIT_COUNT - 4'h1;  // [R15]
    wire go       = (st_q == CCSS_IDLE) && start_ok;
    // Internal clock toggles only while shifting. [R7] [R8]
    wire itog     = !ext_clk && st_q == CCSS_SHIFT && div_hit;
    // The frame ends on the eighth sample edge, so the clock rests idle.
    wire done     = last_b;                                          // [R15]
    // ****************************************************************
    // Edge history and divider.
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_prev_q <= 1'b1;
            divc_q     <= 8'h00;
        end else if (clk_en) begin
            sck_prev_q <= sck_now;
            divc_q     <= (go || div_hit) ? div_q : divc_q - 8'h01;
        end
    end
    // ****************************************************************
    // Shift state.
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q       <= CCSS_IDLE;
            tsr_q      <= 8'hff;
            rsr_q      <= 8'h00;
            bits_q     <= 4'h0;
            isck_q     <= 1'b1;
            rx_act_q   <= 1'b0;
        end else if (clk_en) begin
            if (st_q == CCSS_IDLE) begin
                isck_q <= idle_lvl;                                  // [R16]
                if (go) begin
                    st_q     <= CCSS_SHIFT;
                    tsr_q    <= txbuf_q;                             // [R7]
                    bits_q   <= 4'h0;
                    rx_act_q <= re_q;                                // [R13]
                end
            end else begin
                if (itog) begin
                    isck_q <= !isck_q;
                end
                if (samp_e) begin
                    rsr_q  <= {rsr_q[6:0], rxd_s};
                    bits_q <= bits_q + 4'h1;
                end
                // External clock shifts only on peer edges. [R9]
                if (shft_e && bits_q != 4'h0) begin
                    tsr_q <= {tsr_q[6:0], 1'b1};
                end
                if (done) begin
                    st_q <= CCSS_IDLE;
                end
            end
        end
    end
    assign transmit_data_pin = tsr_q[7];
    assign clock_pin_o       = isck_q;
    assign clock_pin_oe      = !ext_clk;
    wire rx_word = last_b && rx_act_q;                               // [R15]
    // RTS: low when ready, high while receiving, inert internal. [R1] [R2] [R3]
    wire rts_hi  = ext_clk && rts_sel && (st_q == CCSS_SHIFT || rxfull_q
                   || !re_q);
    assign rts_n_pin = rts_hi;
    // ****************************************************************
    // Register writes and status.
    // ****************************************************************
    wire [2:0] ev;
    // Overrun does not raise the receive request. [R10] [R11]
    assign ev[ccss_pkg::IRQ_RX]  = rx_word && !rxfull_q;
    assign ev[ccss_pkg::IRQ_OVR] = rx_word && rxfull_q;
    // Smart-card setup with completion source and error output. [R14]
    wire scm_set = wr_c1 && avs_writedata[ccss_pkg::C1_SCM]
                   && avs_writedata[ccss_pkg::C1_IRS]
                   && avs_writedata[ccss_pkg::C1_ERE] && !(irs_q && ere_q);
    assign ev[ccss_pkg::IRQ_TX]  = (irs_q ? done : go) || scm_set;
    // ****************************************************************
    // Control registers.
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl0_q <= 4'h0;
            div_q   <= ccss_pkg::DIV_RESET;
        end else if (clk_en && wr_c0) begin
            ctrl0_q <= avs_writedata[3:0];
            div_q   <= avs_writedata[ccss_pkg::C0_DIV_LSB +: 8];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            te_q  <= 1'b0;
            re_q  <= 1'b0;
            irs_q <= 1'b0;
            ere_q <= 1'b0;
            scm_q <= 1'b0;
        end else if (clk_en && wr_c1) begin
            te_q  <= avs_writedata[ccss_pkg::C1_TE];
            re_q  <= avs_writedata[ccss_pkg::C1_RE];
            irs_q <= avs_writedata[ccss_pkg::C1_IRS];
            ere_q <= avs_writedata[ccss_pkg::C1_ERE];
            scm_q <= avs_writedata[ccss_pkg::C1_SCM];
        end
    end
    // ****************************************************************
    // Transmit buffer.
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tbe_q   <= 1'b1;
            txbuf_q <= 8'hff;
        end else if (clk_en) begin
            // Dummy word per reception comes from software writes. [R12]
            if (wr_tb) begin
                txbuf_q <= avs_writedata[7:0];
                tbe_q   <= 1'b0;
            end else if (go) begin
                tbe_q <= 1'b1;
            end
        end
    end
    // ****************************************************************
    // Receive buffer and overrun.
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxbuf_q  <= 8'h00;
            rxfull_q <= 1'b0;
            ovr_q    <= 1'b0;
        end else if (clk_en) begin
            if (rx_word) begin
                rxbuf_q  <= {rsr_q[6:0], rxd_s};                     // [R15]
                rxfull_q <= 1'b1;
            end else if (rd_rb) begin
                rxfull_q <= 1'b0;
            end
            if (ev[ccss_pkg::IRQ_OVR]) begin
                ovr_q <= 1'b1;                                       // [R10]
            end else if (wr_c1 && !avs_writedata[ccss_pkg::C1_RE]) begin
                ovr_q <= 1'b0;
            end
        end
    end
    // ****************************************************************
    // Interrupt status and mask.
    // ****************************************************************
    // A new event wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= 3'h0;
            mask_q <= 3'h0;
        end else if (clk_en) begin
            if (wr_mk) begin
                mask_q <= avs_writedata[2:0];
            end
            stat_q <= (stat_q & ~(wr_st ? avs_writedata[2:0] : 3'h0)) | ev;
        end
    end
    // ****************************************************************
    // Bus read path.
    // ****************************************************************
    wire [31:0] c1_rd = {25'h0, scm_q, ere_q, irs_q, rxfull_q, re_q, tbe_q,
                         te_q};
    wire [31:0] rd_mux =
        avs_address == 5'(ccss_pkg::OFF_CTRL0) ? {16'h0, div_q, 4'h0, ctrl0_q}
      : avs_address == 5'(ccss_pkg::OFF_CTRL1) ? c1_rd
      : avs_address == 5'(ccss_pkg::OFF_TXBUF) ? {24'h0, txbuf_q}
      : avs_address == 5'(ccss_pkg::OFF_RXBUF) ? {19'h0, ovr_q, 4'h0, rxbuf_q}
      : avs_address == ccss_pkg::OFF_IRQ_STAT  ? {29'h0, stat_q}
      : avs_address == ccss_pkg::OFF_IRQ_MASK  ? {29'h0, mask_q}
      : 32'h0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ack_q <= 1'b0;
            rdata_q  <= 32'h0;
        end else if (clk_en) begin
            rd_ack_q <= avs_read && !rd_ack_q;
            rdata_q  <= rd_mux;
        end
    end
    assign avs_waitrequest = avs_read && !rd_ack_q;
    assign avs_readdata    = rdata_q;
    assign irq             = |(stat_q & mask_q);
endmodule : ccss_top
`default_nettype wire

/* tb/ccss_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// ********
// Port checker.
// ********
module ccss_sva (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    input  wire logic        clock_pin_o,
    input  wire logic        clock_pin_oe,
    input  wire logic        transmit_data_pin,
    input  wire logic        rts_n_pin,
    input  wire logic        irq
);
    logic txw_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) txw_q <= 1'b0;
        else if (avs_write && avs_address == 5'(ccss_pkg::OFF_TXBUF))
            txw_q <= 1'b1;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    property p_rd_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_nowait; avs_write |-> !avs_waitrequest; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_unmapped; avs_read && !avs_waitrequest && avs_address > 5'h14
        |-> avs_readdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    property p_rts_inert; clock_pin_oe && $past(clock_pin_oe) |-> !rts_n_pin; endproperty
    a_rts_inert: assert property (p_rts_inert) else $error("rts moved");
    property p_rst_idle; $fell(rst) |-> clock_pin_o && transmit_data_pin && !irq; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("idle levels");
    property p_irq_fall; $fell(irq) |-> $past(avs_write); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
    property p_oe_write; $changed(clock_pin_oe) |-> $past(avs_write); endproperty
    a_oe_write: assert property (p_oe_write) else $error("oe changed");
    property p_clk_start; $changed(clock_pin_o) && !$past(avs_write) |-> txw_q; endproperty
    a_clk_start: assert property (p_clk_start) else $error("early clock");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_irq: cover property ($rose(irq));
    c_clk: cover property (clock_pin_oe && $changed(clock_pin_o));
endmodule : ccss_sva
bind ccss_top ccss_sva ccss_sva_inst (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe),
    .transmit_data_pin(transmit_data_pin), .rts_n_pin(rts_n_pin), .irq(irq));
`default_nettype wire

/* tb/ccss_peer.sv */
`timescale 1ns/100ps
`default_nettype none
// ********
// Serial peer model.
// ********
module ccss_peer (
    input  wire logic       sclk,
    input  wire logic       pol,
    input  wire logic       txd,
    output logic            clk_o,
    output logic            rxd,
    output logic [7:0]      word_o
);
    logic       ph = 1'b0;
    logic [7:0] sh_q = 8'h00;
    assign clk_o = ph ^ !pol;
    initial rxd = 1'b1;
    initial word_o = 8'h00;
    task automatic load(input logic [7:0] w);
        sh_q = w;
        rxd = ~w[7];
    endtask : load
    task automatic pulses();
        repeat (16) #24 ph = ~ph;
    endtask : pulses
    always @(posedge (sclk ^ pol)) word_o <= {word_o[6:0], txd};
    always @(negedge (sclk ^ pol)) begin
        rxd <= sh_q[7];
        sh_q <= {sh_q[6:0], ~sh_q[0]};
    end
endmodule : ccss_peer
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ********
// Bench top.
// ********
module tb_top;
    localparam logic [4:0] a_c0 = 5'(ccss_pkg::OFF_CTRL0);
    localparam logic [4:0] a_c1 = 5'(ccss_pkg::OFF_CTRL1);
    localparam logic [4:0] a_rx = 5'(ccss_pkg::OFF_RXBUF);
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic        cts_n = 1'b1, pol = 1'b0, ext = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = 32'h0;
    logic [7:0]  tw, pw;
    logic [31:0] exp_q[$], msk_q[$];
    int          err_count = 0, n_compared = 0;
    wire  [31:0] rdat;
    wire  [7:0]  pword;
    wire         wreq, so, soe, txd, rts_n, irq, pclk, rxd;
    wire         sclk = soe ? so : pclk;
    always #2.5 clk = ~clk;
    ccss_top ccss_top_inst (.clk(clk), .rst(rst), .clk_en(1'b1),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .clock_pin_i(sclk), .clock_pin_o(so),
        .clock_pin_oe(soe), .transmit_data_pin(txd), .receive_data_pin(rxd),
        .cts_n_pin(cts_n), .rts_n_pin(rts_n), .irq(irq));
    ccss_peer ccss_peer_inst (.sclk(sclk), .pol(pol), .txd(txd),
        .clk_o(pclk), .rxd(rxd), .word_o(pword));
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, s);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 99);
        if (wreq !== 1'b0) begin
            err_count++;
            print_verdict();
        end
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rd_reg(input logic [4:0] a, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rd_reg
    always @(negedge clk) begin
        if (rd && wreq === 1'b0 && exp_q.size() > 0)
            chk("readdata", exp_q.pop_front(), rdat & msk_q.pop_front());
    end
    task automatic frame();
        int n;
        tw = 8'($urandom);
        pw = 8'($urandom);
        ccss_peer_inst.load(pw);
        bus(1'b1, 5'h08, {24'h0, tw});
        if (cts_n) begin
            repeat (40) @(posedge clk);
            rd_reg(a_c1, 32'h0, 32'h2);
            cts_n <= 1'b0;
        end
        repeat (20) @(posedge clk);
        if (ext) ccss_peer_inst.pulses();
        n = 0;
        while (irq !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("frame done", 32'h1, {31'h0, irq});
        if (irq !== 1'b1) print_verdict();
    endtask : frame
    initial begin
        void'($urandom(18));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(a_c1, 32'h2, 32'hf);
        bus(1'b1, 5'h18, 32'hffffffff);
        rd_reg(5'h18, 32'h0, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            ext <= i[1];
            pol <= i[0];
            cts_n <= 1'b1;
            bus(1'b1, a_c0, {16'h0, ccss_pkg::DIV_RESET, 6'h03, i[0], i[1]});
            bus(1'b1, ccss_pkg::OFF_IRQ_MASK, 32'h2);
            bus(1'b1, a_c1, 32'h5);
            repeat (3) @(negedge clk);
            chk("rts ready", 32'h0, {31'h0, rts_n});
            frame();
            chk("peer word", {24'h0, tw}, {24'h0, pword});
            chk("rts busy", {31'h0, ext}, {31'h0, rts_n});
            rd_reg(a_rx, {24'h0, pw}, 32'h10ff);
            bus(1'b1, ccss_pkg::OFF_IRQ_STAT, 32'h7);
            @(negedge clk);
            chk("irq clear", 32'h0, {31'h0, irq});
        end
        frame();
        bus(1'b1, ccss_pkg::OFF_IRQ_STAT, 32'h7);
        bus(1'b1, ccss_pkg::OFF_IRQ_MASK, 32'h4);
        frame();
        rd_reg(ccss_pkg::OFF_IRQ_STAT, 32'h4, 32'h6);
        rd_reg(a_rx, 32'h1000, 32'h1000);
        bus(1'b1, ccss_pkg::OFF_IRQ_STAT, 32'h7);
        bus(1'b1, a_c1, 32'h70);
        rd_reg(ccss_pkg::OFF_IRQ_STAT, 32'h1, 32'h1);
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
